// ### mdbcp_defs.svh
// Purpose: Shared constants of the coil and parameter command handler
// Assumes: Included by every design file that decodes frames or coils
// Notes: Coil and register fields are zero-based, as they travel on the wire
`ifndef MDBCP_DEFS_SVH
`define MDBCP_DEFS_SVH
`define MDBCP_FC_RD_COILS 8'h01
`define MDBCP_FC_RD_REGS 8'h03
`define MDBCP_FC_WR_COIL 8'h05
`define MDBCP_FC_WR_REG 8'h06
`define MDBCP_FC_WR_COILS 8'h0f
`define MDBCP_FC_WR_REGS 8'h10
`define MDBCP_BCAST_ADDR 8'h00
`define MDBCP_FORCE_ON 16'hff00
`define MDBCP_FORCE_OFF 16'h0000
`define MDBCP_COIL_SETPT 16'h0010
`define MDBCP_COIL_STATUS 16'h0020
`define MDBCP_COIL_NVCTRL 16'h0040
`define MDBCP_COIL_BLOCK 16'h0010
`define MDBCP_COIL_COUNT 17'h00041
`define MDBCP_COIL_MAP_BITS 80
`define MDBCP_COIL_MAP_END 16'h0050
`define MDBCP_REG_MAX 16'h000a
`define MDBCP_REG_INDEX 16'h0008
`define MDBCP_ADDR_BIAS 16'h0001
`define MDBCP_PNU_SCALE 16'h000a
`define MDBCP_HDR_LEN 8'h07
`define MDBCP_SHORT_LEN 8'h06
`define MDBCP_RD_HDR_LEN 8'h03
`endif

// ### mdbcp_pkg.sv
// Purpose: Types of the coil and parameter command handler
// Assumes: Nothing beyond SystemVerilog
// Notes: Numbers live in mdbcp_defs.svh
package mdbcp_pkg;
  typedef logic [7:0] mdbcp_byte_t;
  typedef logic [15:0] mdbcp_word_t;
  typedef enum logic [2:0] {
    st_rx = 3'b000,
    st_chk = 3'b001,
    st_wf = 3'b010,
    st_wd = 3'b011,
    st_tf = 3'b100,
    st_tl = 3'b101,
    st_tw = 3'b110
  } mdbcp_state_t;
endpackage

// ### mdbcp_mem_if.sv
// Purpose: Port bundle of a small memory with registered read data
// Assumes: Written and read on the same clock
// Notes: Read data appear one edge after the read address
`timescale 1ns/10ps
interface mdbcp_mem_if #(
  parameter int DW = 8,
  parameter int AW = 5
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport host (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ### mdbcp_mem.sv
// Purpose: Small memory, one write port and one registered read port
// Assumes: Single clock
// Notes: A read of the word being written returns the old contents
`timescale 1ns/10ps
module mdbcp_mem #(
  parameter int DW = 8,
  parameter int AW = 5
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  mdbcp_mem_if.mem port
);
  logic [DW-1:0] store [2**AW];
  logic [DW-1:0] rd_reg;
  logic [DW-1:0] rd_next;

  always_comb begin
    rd_next = store[port.rd_addr];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // Contents need no reset; software defines them before reading
  always_ff @(posedge clk_sys) begin
    if (port.wr_en) begin
      store[port.wr_addr] <= port.wr_data;
    end
  end

  assign port.rd_data = rd_reg;
endmodule

// ### mdbcp_coil_bank.sv
// Purpose: Coil space: speed setpoint, drive status word, parameter write control
// Assumes: Fields are zero-based coil numbers
// Notes: Coils outside the mapped blocks read zero and ignore writes
`timescale 1ns/10ps
`include "mdbcp_defs.svh"
module mdbcp_coil_bank (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire mdbcp_pkg::mdbcp_word_t wr_field,
  input wire logic wr_val,
  input wire mdbcp_pkg::mdbcp_word_t rd_base,
  output mdbcp_pkg::mdbcp_byte_t rd_byte,
  input wire mdbcp_pkg::mdbcp_word_t drive_status_word,
  output mdbcp_pkg::mdbcp_word_t speed_setpoint,
  output logic nv_ctrl
);
  import mdbcp_pkg::*;
  mdbcp_word_t setpt_reg;
  mdbcp_word_t setpt_next;
  logic nv_reg;
  logic nv_next;
  logic [`MDBCP_COIL_MAP_BITS-1:0] coil_map;
  logic [`MDBCP_COIL_MAP_BITS-1:0] shifted;

  always_comb begin
    setpt_next = setpt_reg;
    nv_next = nv_reg;
    if (wr_en) begin
      if (wr_field >= `MDBCP_COIL_SETPT && wr_field < `MDBCP_COIL_SETPT + `MDBCP_COIL_BLOCK) begin
        setpt_next[wr_field[3:0]] = wr_val;
      end else if (wr_field == `MDBCP_COIL_NVCTRL) begin
        nv_next = wr_val;
      end
    end
  end

  // Bit n of the map is the coil at zero-based field n
  always_comb begin
    coil_map = {15'h0000, nv_reg, 16'h0000, drive_status_word, setpt_reg, 16'h0000};
    shifted = coil_map >> rd_base[6:0];
    rd_byte = (rd_base < `MDBCP_COIL_MAP_END) ? shifted[7:0] : 8'h00;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      setpt_reg <= 16'h0000;
      nv_reg <= 1'b0;
    end else begin
      setpt_reg <= setpt_next;
      nv_reg <= nv_next;
    end
  end

  assign speed_setpoint = setpt_reg;
  assign nv_ctrl = nv_reg;
endmodule

// ### mdbcp_top.sv
// Purpose: Follower-side command handler for coil and parameter access
// Assumes: Byte stream from a receiver that strips and checks the trailing check
// Notes: Responses leave as a byte stream; the transmitter appends the check
// Summary of operation
// - Integer parameters sit in holding registers and are read with function 03.
// - 16-bit parameters use single-register preset, 32-bit use multiple-register preset.
// - Register reads of one up to ten registers are accepted.
// - Text parameters are read with 03, written with 10, two characters per register.
// - Coil reads return coil states; broadcast coil reads are ignored.
// - Addresses on the wire are zero-based, one less than the coil number.
// - Coil read data pack one coil per bit, first coil in bit zero.
// - Unused high bits of the last byte are zero; byte count counts data bytes.
// - Single coil write uses 05 with force value FF00 for on, 0000 off.
// - A single coil write is answered with an echo of the query.
// - Broadcast coil writes take effect in every follower.
// - Multiple coil write carries start, quantity, byte count and packed bits.
// - Multiple coil write answer is address, function, start and quantity only.
// - Coil 65, field 64, is the parameter write control.
// - Coils 33 to 48 show the drive status word.
// - Coils 17 to 32 hold the speed setpoint.
// - Parameter values travel as whole numbers, scaled outside.
// - Coil 65 set stores writes in non-volatile and working memory.
// - A parameter's register is ten times its number.
// - Holding register 9 holds the array index for later accesses.
`timescale 1ns/10ps
`include "mdbcp_defs.svh"
module mdbcp_top #(
  parameter int FAW = 5,
  parameter int RAW = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire mdbcp_pkg::mdbcp_byte_t station_addr,
  input wire logic rx_valid,
  input wire mdbcp_pkg::mdbcp_byte_t rx_data,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic tx_ready,
  output logic tx_valid,
  output mdbcp_pkg::mdbcp_byte_t tx_data,
  output logic tx_last,
  input wire mdbcp_pkg::mdbcp_word_t drive_status_word,
  output mdbcp_pkg::mdbcp_word_t speed_setpoint,
  output logic param_store_nv,
  output logic param_wr_valid,
  output mdbcp_pkg::mdbcp_word_t param_wr_num,
  output logic [3:0] param_wr_sub,
  output mdbcp_pkg::mdbcp_word_t param_wr_index,
  output mdbcp_pkg::mdbcp_word_t param_wr_data,
  output logic param_wr_nv
);
  import mdbcp_pkg::*;

  mdbcp_state_t state_reg;
  mdbcp_state_t state_next;
  logic [FAW:0] len_reg;
  logic [FAW:0] len_next;
  logic ovf_reg;
  logic ovf_next;
  mdbcp_byte_t hdr_reg [0:6];
  mdbcp_byte_t hdr_next [0:6];
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  mdbcp_byte_t hi_reg;
  mdbcp_byte_t hi_next;
  mdbcp_word_t idx_reg;
  mdbcp_word_t idx_next;
  logic tx_valid_reg;
  logic tx_valid_next;
  mdbcp_byte_t tx_data_reg;
  mdbcp_byte_t tx_data_next;
  logic tx_last_reg;
  logic tx_last_next;
  logic pw_valid_reg;
  logic pw_valid_next;
  mdbcp_word_t pw_num_reg;
  mdbcp_word_t pw_num_next;
  logic [3:0] pw_sub_reg;
  logic [3:0] pw_sub_next;
  mdbcp_word_t pw_index_reg;
  mdbcp_word_t pw_index_next;
  mdbcp_word_t pw_data_reg;
  mdbcp_word_t pw_data_next;
  logic pw_nv_reg;
  logic pw_nv_next;

  mdbcp_byte_t fc;
  mdbcp_byte_t bc;
  mdbcp_byte_t len8;
  mdbcp_byte_t k;
  mdbcp_byte_t rsp_len;
  mdbcp_byte_t tx_byte;
  mdbcp_byte_t coil_mask;
  mdbcp_byte_t coil_byte;
  mdbcp_word_t st_w;
  mdbcp_word_t qv_w;
  mdbcp_word_t coil_bc;
  mdbcp_word_t qty2;
  mdbcp_word_t remain;
  mdbcp_word_t coil_base;
  mdbcp_word_t regnum;
  logic [16:0] end_w;
  logic bcast;
  logic for_us;
  logic frame_ok;
  logic last;
  logic reg_we;
  mdbcp_word_t wr_field;
  mdbcp_word_t wr_word;
  logic coil_we;
  mdbcp_word_t coil_field;
  logic coil_val;
  logic nv_ctrl;

  mdbcp_mem_if #(.DW(8), .AW(FAW)) frm_if ();
  mdbcp_mem_if #(.DW(16), .AW(RAW)) reg_if ();

  // Frame buffer holds the received bytes for the write loops
  mdbcp_mem #(.DW(8), .AW(FAW)) u_frame (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .port(frm_if.mem)
  );

  // Working copy of the holding registers, indexed by the low address bits
  mdbcp_mem #(.DW(16), .AW(RAW)) u_regs (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .port(reg_if.mem)
  );

  mdbcp_coil_bank u_coils (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .wr_en(coil_we),
    .wr_field(coil_field),
    .wr_val(coil_val),
    .rd_base(coil_base),
    .rd_byte(coil_byte),
    .drive_status_word(drive_status_word),
    .speed_setpoint(speed_setpoint),
    .nv_ctrl(nv_ctrl)
  );

  assign fc = hdr_reg[1];
  assign bc = hdr_reg[6];
  assign st_w = {hdr_reg[2], hdr_reg[3]};
  assign qv_w = {hdr_reg[4], hdr_reg[5]};
  assign len8 = 8'(len_reg);
  assign bcast = hdr_reg[0] == `MDBCP_BCAST_ADDR;
  assign for_us = hdr_reg[0] == station_addr;
  assign end_w = {1'b0, st_w} + {1'b0, qv_w};
  assign coil_bc = (qv_w + 16'h0007) >> 3;
  assign qty2 = {qv_w[14:0], 1'b0};
  assign k = cnt_reg - `MDBCP_RD_HDR_LEN;
  assign coil_base = st_w + {5'h00, k, 3'h0};
  assign remain = qv_w - {5'h00, k, 3'h0};

  // Both read addresses follow the byte counter; data arrive one state later
  assign reg_if.rd_addr = RAW'(st_w + {9'h000, k[7:1]});
  assign frm_if.rd_addr = FAW'((fc == `MDBCP_FC_WR_COILS) ? {3'h0, cnt_reg[7:3]} + `MDBCP_HDR_LEN
                                                          : cnt_reg + `MDBCP_HDR_LEN);
  assign reg_if.wr_en = reg_we;
  assign reg_if.wr_addr = RAW'(wr_field);
  assign reg_if.wr_data = wr_word;

  always_comb begin
    frame_ok = 1'b0;
    case (fc)
      `MDBCP_FC_RD_COILS: begin
        frame_ok = !bcast && len8 == `MDBCP_SHORT_LEN && qv_w != 16'h0000
                   && end_w <= `MDBCP_COIL_COUNT;
      end
      `MDBCP_FC_RD_REGS: begin
        frame_ok = !bcast && len8 == `MDBCP_SHORT_LEN && qv_w != 16'h0000
                   && qv_w <= `MDBCP_REG_MAX;
      end
      `MDBCP_FC_WR_COIL: begin
        frame_ok = len8 == `MDBCP_SHORT_LEN
                   && (qv_w == `MDBCP_FORCE_ON || qv_w == `MDBCP_FORCE_OFF)
                   && (st_w == `MDBCP_COIL_NVCTRL
                       || (st_w >= `MDBCP_COIL_SETPT && st_w < `MDBCP_COIL_SETPT + `MDBCP_COIL_BLOCK));
      end
      `MDBCP_FC_WR_REG: begin
        frame_ok = len8 == `MDBCP_SHORT_LEN;
      end
      `MDBCP_FC_WR_COILS: begin
        frame_ok = qv_w != 16'h0000 && end_w <= `MDBCP_COIL_COUNT && coil_bc[15:8] == 8'h00
                   && bc == coil_bc[7:0] && len8 == `MDBCP_HDR_LEN + bc;
      end
      `MDBCP_FC_WR_REGS: begin
        frame_ok = qv_w != 16'h0000 && qv_w <= `MDBCP_REG_MAX
                   && bc == qty2[7:0] && len8 == `MDBCP_HDR_LEN + bc;
      end
      default: begin
        frame_ok = 1'b0;
      end
    endcase
    frame_ok = frame_ok && (for_us || bcast);
  end

  // Response length and the byte due at the current count
  always_comb begin
    coil_mask = (remain >= 16'h0008) ? 8'hff : ~(8'hff << remain[2:0]);
    tx_byte = 8'h00;
    if (cnt_reg < `MDBCP_SHORT_LEN) begin
      tx_byte = hdr_reg[cnt_reg[2:0]];
    end
    case (fc)
      `MDBCP_FC_RD_COILS: begin
        rsp_len = `MDBCP_RD_HDR_LEN + coil_bc[7:0];
        if (cnt_reg == 8'h02) begin
          tx_byte = coil_bc[7:0];
        end else if (cnt_reg > 8'h02) begin
          tx_byte = coil_byte & coil_mask;
        end
      end
      `MDBCP_FC_RD_REGS: begin
        rsp_len = `MDBCP_RD_HDR_LEN + qty2[7:0];
        if (cnt_reg == 8'h02) begin
          tx_byte = qty2[7:0];
        end else if (cnt_reg > 8'h02) begin
          tx_byte = k[0] ? reg_if.rd_data[7:0] : reg_if.rd_data[15:8];
        end
      end
      default: begin
        rsp_len = `MDBCP_SHORT_LEN;
      end
    endcase
  end

  always_comb begin
    state_next = state_reg;
    len_next = len_reg;
    ovf_next = ovf_reg;
    hdr_next = hdr_reg;
    cnt_next = cnt_reg;
    hi_next = hi_reg;
    idx_next = idx_reg;
    tx_valid_next = tx_valid_reg;
    tx_data_next = tx_data_reg;
    tx_last_next = tx_last_reg;
    pw_valid_next = 1'b0;
    pw_num_next = pw_num_reg;
    pw_sub_next = pw_sub_reg;
    pw_index_next = pw_index_reg;
    pw_data_next = pw_data_reg;
    pw_nv_next = pw_nv_reg;
    frm_if.wr_en = 1'b0;
    frm_if.wr_addr = len_reg[FAW-1:0];
    frm_if.wr_data = rx_data;
    reg_we = 1'b0;
    wr_field = st_w;
    wr_word = qv_w;
    coil_we = 1'b0;
    coil_field = st_w;
    coil_val = qv_w[15];
    last = 1'b0;
    regnum = 16'h0000;
    unique case (state_reg)
      st_rx: begin
        if (rx_valid) begin
          // Bytes past the buffer mark the frame bad instead of wrapping
          if (len_reg[FAW]) begin
            ovf_next = 1'b1;
          end else begin
            frm_if.wr_en = 1'b1;
            len_next = len_reg + 1'b1;
            if (len8 < `MDBCP_HDR_LEN) begin
              hdr_next[len_reg[2:0]] = rx_data;
            end
          end
        end
        if (rx_end) begin
          if (rx_crc_ok && !ovf_reg) begin
            state_next = st_chk;
          end else begin
            len_next = '0;
            ovf_next = 1'b0;
          end
        end
      end
      st_chk: begin
        len_next = '0;
        ovf_next = 1'b0;
        cnt_next = 8'h00;
        if (!frame_ok) begin
          state_next = st_rx;
        end else begin
          if (fc == `MDBCP_FC_WR_COIL) begin
            coil_we = 1'b1;
          end
          if (fc == `MDBCP_FC_WR_REG) begin
            reg_we = 1'b1;
          end
          if (fc == `MDBCP_FC_WR_COILS || fc == `MDBCP_FC_WR_REGS) begin
            state_next = st_wf;
          end else if (bcast) begin
            state_next = st_rx;
          end else begin
            state_next = st_tf;
          end
        end
      end
      st_wf: begin
        state_next = st_wd;
      end
      st_wd: begin
        if (fc == `MDBCP_FC_WR_COILS) begin
          coil_we = 1'b1;
          coil_field = st_w + {8'h00, cnt_reg};
          coil_val = frm_if.rd_data[cnt_reg[2:0]];
          last = {8'h00, cnt_reg} == qv_w - 16'h0001;
        end else begin
          if (!cnt_reg[0]) begin
            hi_next = frm_if.rd_data;
          end else begin
            reg_we = 1'b1;
            wr_field = st_w + {9'h000, cnt_reg[7:1]};
            wr_word = {hi_reg, frm_if.rd_data};
          end
          last = {8'h00, cnt_reg} == qty2 - 16'h0001;
        end
        if (last) begin
          cnt_next = 8'h00;
          state_next = bcast ? st_rx : st_tf;
        end else begin
          cnt_next = cnt_reg + 8'h01;
          state_next = st_wf;
        end
      end
      st_tf: begin
        state_next = st_tl;
      end
      st_tl: begin
        tx_valid_next = 1'b1;
        tx_data_next = tx_byte;
        tx_last_next = cnt_reg == rsp_len - 8'h01;
        state_next = st_tw;
      end
      st_tw: begin
        if (tx_ready) begin
          tx_valid_next = 1'b0;
          tx_last_next = 1'b0;
          if (tx_last_reg) begin
            state_next = st_rx;
          end else begin
            cnt_next = cnt_reg + 8'h01;
            state_next = st_tf;
          end
        end
      end
      default: begin
        state_next = st_rx;
      end
    endcase
    if (reg_we) begin
      regnum = wr_field + `MDBCP_ADDR_BIAS;
      pw_valid_next = 1'b1;
      pw_num_next = regnum / `MDBCP_PNU_SCALE;
      pw_sub_next = 4'(regnum % `MDBCP_PNU_SCALE);
      pw_index_next = idx_reg;
      pw_data_next = wr_word;
      pw_nv_next = nv_ctrl;
      if (wr_field == `MDBCP_REG_INDEX) begin
        idx_next = wr_word;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= st_rx;
      len_reg <= '0;
      ovf_reg <= 1'b0;
      for (int i = 0; i < 7; i++) begin
        hdr_reg[i] <= 8'h00;
      end
      cnt_reg <= 8'h00;
      hi_reg <= 8'h00;
      idx_reg <= 16'h0000;
      tx_valid_reg <= 1'b0;
      tx_data_reg <= 8'h00;
      tx_last_reg <= 1'b0;
      pw_valid_reg <= 1'b0;
      pw_num_reg <= 16'h0000;
      pw_sub_reg <= 4'h0;
      pw_index_reg <= 16'h0000;
      pw_data_reg <= 16'h0000;
      pw_nv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      len_reg <= len_next;
      ovf_reg <= ovf_next;
      hdr_reg <= hdr_next;
      cnt_reg <= cnt_next;
      hi_reg <= hi_next;
      idx_reg <= idx_next;
      tx_valid_reg <= tx_valid_next;
      tx_data_reg <= tx_data_next;
      tx_last_reg <= tx_last_next;
      pw_valid_reg <= pw_valid_next;
      pw_num_reg <= pw_num_next;
      pw_sub_reg <= pw_sub_next;
      pw_index_reg <= pw_index_next;
      pw_data_reg <= pw_data_next;
      pw_nv_reg <= pw_nv_next;
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_data = tx_data_reg;
  assign tx_last = tx_last_reg;
  assign param_store_nv = nv_ctrl;
  assign param_wr_valid = pw_valid_reg;
  assign param_wr_num = pw_num_reg;
  assign param_wr_sub = pw_sub_reg;
  assign param_wr_index = pw_index_reg;
  assign param_wr_data = pw_data_reg;
  assign param_wr_nv = pw_nv_reg;
endmodule

// ### mdbcp_top_sva.sv
// Purpose: Port-level checks of the coil and parameter command handler
// Assumes: Frames arrive only while the handler is idle
// Notes: Only the address byte of each frame is tracked
`timescale 1ns/10ps
module mdbcp_top_sva #(
  parameter int FAW = 5,
  parameter int RAW = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire mdbcp_pkg::mdbcp_byte_t station_addr,
  input wire logic rx_valid,
  input wire mdbcp_pkg::mdbcp_byte_t rx_data,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire mdbcp_pkg::mdbcp_byte_t tx_data,
  input wire logic tx_last,
  input wire mdbcp_pkg::mdbcp_word_t drive_status_word,
  input wire mdbcp_pkg::mdbcp_word_t speed_setpoint,
  input wire logic param_store_nv,
  input wire logic param_wr_valid,
  input wire mdbcp_pkg::mdbcp_word_t param_wr_num,
  input wire logic [3:0] param_wr_sub,
  input wire mdbcp_pkg::mdbcp_word_t param_wr_index,
  input wire mdbcp_pkg::mdbcp_word_t param_wr_data,
  input wire logic param_wr_nv
);
  import mdbcp_pkg::*;
  mdbcp_byte_t fb_reg;
  mdbcp_byte_t fb_next;
  logic got_reg;
  logic got_next;
  always_comb begin
    fb_next = fb_reg;
    got_next = got_reg;
    if (rx_end) begin
      got_next = 1'b0;
    end else if (rx_valid && !got_reg) begin
      fb_next = rx_data;
      got_next = 1'b1;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fb_reg <= 8'h00;
      got_reg <= 1'b0;
    end else begin
      fb_reg <= fb_next;
      got_reg <= got_next;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("answer byte changed before accept");
  AST_SILENT: assert property (rx_end && !tx_valid && fb_reg != station_addr |=> !tx_valid [*8])
    else $error("answer to a frame not for this station");
  AST_BADCRC: assert property (rx_end && !rx_crc_ok && !tx_valid |=>
    (!tx_valid && !param_wr_valid && $stable(speed_setpoint) && $stable(param_store_nv)) [*6])
    else $error("failed frame had an effect");
  AST_LAST: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid [*8])
    else $error("byte sent after the final one");
  AST_NEXT: assert property (tx_valid && tx_ready && !tx_last |=> !tx_valid ##1 !tx_valid ##[1:3] tx_valid)
    else $error("answer stopped before its final byte");
  AST_FIRST: assert property (rx_end && rx_crc_ok && fb_reg == station_addr ##4 tx_valid |-> tx_data == fb_reg)
    else $error("answer does not start with the station address");
  AST_NV: assert property (param_wr_valid |-> param_wr_nv == param_store_nv)
    else $error("storage flag differs from write control coil");
  AST_PULSE: assert property (param_wr_valid |=> !param_wr_valid [*3])
    else $error("register write strobes too close");
  AST_SUB: assert property (param_wr_valid |-> param_wr_sub < 4'ha)
    else $error("sub-register index above nine");
  cover property (tx_valid && tx_ready && tx_last);
  cover property (param_wr_valid);
  cover property ($changed(speed_setpoint));
endmodule
bind mdbcp_top mdbcp_top_sva #(.FAW(FAW), .RAW(RAW)) u_sva (
  .clk_sys(clk_sys), .reset_n(reset_n), .station_addr(station_addr),
  .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .drive_status_word(drive_status_word), .speed_setpoint(speed_setpoint),
  .param_store_nv(param_store_nv), .param_wr_valid(param_wr_valid),
  .param_wr_num(param_wr_num), .param_wr_sub(param_wr_sub),
  .param_wr_index(param_wr_index), .param_wr_data(param_wr_data), .param_wr_nv(param_wr_nv));

// ### mdbcp_master_model.sv
// Purpose: Bus controller model feeding frames and taking answers
// Assumes: Check bytes are stripped; rx_crc_ok carries the verdict
// Notes: Released data line shows the inverse of its last byte
`timescale 1ns/10ps
module mdbcp_master_model (
  input wire logic clk_sys,
  output logic rx_valid,
  output mdbcp_pkg::mdbcp_byte_t rx_data,
  output logic rx_end,
  output logic rx_crc_ok,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire mdbcp_pkg::mdbcp_byte_t tx_data,
  input wire logic tx_last
);
  import mdbcp_pkg::*;
  mdbcp_byte_t frm[$];
  mdbcp_byte_t rsp[$];
  logic lst;
  int nlast;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_end = 1'b0;
    rx_crc_ok = 1'b0;
    tx_ready = 1'b0;
  end
  // Slow answers pause before each byte so holding is exercised
  task xfer(input logic ok, input int slow, input int n);
    int w;
    rsp = {};
    nlast = 0;
    lst = 1'b0;
    foreach (frm[i]) begin
      @(posedge clk_sys);
      #1;
      rx_valid = 1'b1;
      rx_data = frm[i];
    end
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_end = 1'b1;
    rx_crc_ok = ok;
    @(posedge clk_sys);
    #1;
    rx_end = 1'b0;
    rx_crc_ok = ~ok;
    repeat (n) begin
      repeat (slow) begin
        @(posedge clk_sys);
        #1;
      end
      tx_ready = 1'b1;
      w = 0;
      do begin
        @(posedge clk_sys);
        w++;
      end while (tx_valid !== 1'b1 && w < 300);
      rsp.push_back(tx_valid === 1'b1 ? tx_data : 8'hxx);
      lst = tx_last;
      if (tx_last === 1'b1) nlast++;
      #1;
      if (slow > 0) tx_ready = 1'b0;
    end
    if (slow == 0) tx_ready = 1'b0;
  endtask
endmodule

// ### modbus_rtu_coil_param_access_tb_top.sv
// Purpose: Directed scenarios for the coil and parameter handler
// Assumes: Station address 01
// Notes: Each scenario judges its own answers
`timescale 1ns/10ps
module modbus_rtu_coil_param_access_tb_top;
  import mdbcp_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic rx_valid, rx_end, rx_crc_ok, tx_ready, tx_valid, tx_last;
  logic param_store_nv, param_wr_valid, param_wr_nv;
  mdbcp_byte_t rx_data, tx_data;
  mdbcp_word_t dsw = 16'h0000;
  mdbcp_byte_t stn = 8'h01;
  mdbcp_word_t speed_setpoint, param_wr_num, param_wr_index, param_wr_data;
  logic [3:0] param_wr_sub;
  mdbcp_byte_t ex[$];
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_wr = 0;
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (param_wr_valid === 1'b1) n_wr++;
  mdbcp_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .station_addr(stn),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .drive_status_word(dsw), .speed_setpoint(speed_setpoint),
    .param_store_nv(param_store_nv), .param_wr_valid(param_wr_valid),
    .param_wr_num(param_wr_num), .param_wr_sub(param_wr_sub),
    .param_wr_index(param_wr_index), .param_wr_data(param_wr_data), .param_wr_nv(param_wr_nv));
  mdbcp_master_model m (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last));
  task chk_w(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task run(input logic ok, input int slow);
    int k;
    m.xfer(ok, slow, ex.size());
    if (ex.size() > 0) begin
      chk_w(m.rsp.size(), ex.size());
      foreach (ex[i]) chk_w(m.rsp[i], ex[i]);
      chk_w(m.nlast, 16'h0001);
      chk_w(m.lst, 1'b1);
    end else begin
      k = 0;
      repeat (12) @(posedge clk_sys) if (tx_valid !== 1'b0) k++;
      chk_w(k, 16'h0000);
    end
  endtask
  task t_rd_status;
    dsw = 16'h0607;
    m.frm = '{8'h01, 8'h01, 8'h00, 8'h20, 8'h00, 8'h10};
    ex = '{8'h01, 8'h01, 8'h02, 8'h07, 8'h06};
    run(1'b1, 3);
    dsw = 16'h00fd;
    m.frm = '{8'h01, 8'h01, 8'h00, 8'h20, 8'h00, 8'h03};
    ex = '{8'h01, 8'h01, 8'h01, 8'h05};
    run(1'b1, 0);
    $display("t_rd_status done");
  endtask
  task t_coil;
    mdbcp_byte_t v;
    for (int i = 0; i < 3; i++) begin
      v = (i == 1) ? 8'h00 : 8'hff;
      m.frm = '{8'h01, 8'h05, 8'h00, 8'h40, v, 8'h00};
      ex = m.frm;
      run(1'b1, i);
      chk_w(param_store_nv, v[0]);
      m.frm = '{8'h01, 8'h01, 8'h00, 8'h40, 8'h00, 8'h01};
      ex = '{8'h01, 8'h01, 8'h01, {7'h00, v[0]}};
      run(1'b1, 0);
    end
    m.frm = '{8'h01, 8'h05, 8'h00, 8'h40, 8'h00, 8'h00};
    ex = {};
    run(1'b0, 0);
    chk_w(param_store_nv, 1'b1);
    $display("t_coil done");
  endtask
  task t_multi;
    m.frm = '{8'h01, 8'h0f, 8'h00, 8'h10, 8'h00, 8'h10, 8'h02, 8'h20, 8'h00};
    ex = '{8'h01, 8'h0f, 8'h00, 8'h10, 8'h00, 8'h10};
    run(1'b1, 1);
    chk_w(speed_setpoint, 16'h0020);
    stn = 8'h02;
    m.frm = '{8'h00, 8'h05, 8'h00, 8'h10, 8'hff, 8'h00};
    ex = {};
    run(1'b1, 0);
    m.frm = '{8'h01, 8'h05, 8'h00, 8'h11, 8'hff, 8'h00};
    run(1'b1, 0);
    stn = 8'h01;
    m.frm = '{8'h01, 8'h01, 8'h00, 8'h10, 8'h00, 8'h10};
    ex = '{8'h01, 8'h01, 8'h02, 8'h21, 8'h00};
    run(1'b1, 0);
    m.frm = '{8'h00, 8'h01, 8'h00, 8'h10, 8'h00, 8'h10};
    ex = {};
    run(1'b1, 0);
    $display("t_multi done");
  endtask
  task t_regs;
    m.frm = '{8'h01, 8'h06, 8'h00, 8'h08, 8'h00, 8'h02};
    ex = m.frm;
    run(1'b1, 0);
    m.frm = '{8'h01, 8'h10, 8'h04, 8'hd7, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h02, 8'he2};
    ex = '{8'h01, 8'h10, 8'h04, 8'hd7, 8'h00, 8'h02};
    run(1'b1, 2);
    chk_w(n_wr, 16'h0003);
    chk_w(param_wr_num, 16'h007c);
    chk_w(param_wr_sub, 4'h1);
    chk_w(param_wr_data, 16'h02e2);
    chk_w(param_wr_index, 16'h0002);
    chk_w(param_wr_nv, 1'b1);
    m.frm = '{8'h01, 8'h03, 8'h04, 8'hd7, 8'h00, 8'h02};
    ex = '{8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h02, 8'he2};
    run(1'b1, 0);
    m.frm = '{8'h01, 8'h03, 8'h04, 8'hd7, 8'h00, 8'h0b};
    ex = {};
    run(1'b1, 0);
    $display("t_regs done");
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    t_rd_status();
    t_coil();
    t_multi();
    t_regs();
    final_report();
  end
  // Tests take some 500 cycles; 20000 cycles, forty times that, means a hang
  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end
endmodule
